// *** src/periodic_register_transfer_peer.v ***
/*
 * Periodic register transfer and peer broadcast engine with its APB
 * register file and a word mailbox. Assumes one clock, a network side that
 * acknowledges each word message on the same clock, and a mode strap pin.
 */
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "xfer_peer_defs.vh"
module periodic_register_transfer_peer #(
	parameter IDX_W = 8,
	parameter CENT_CYC = `CENT_NS / `CLK_PERIOD_NS,
	parameter MS_CYC = `MILLI_NS / `CLK_PERIOD_NS
) (
	input wire SYS_CLK_I,
	input wire RST_I,
	input wire CE_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [11:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output wire PREADY_O,
	output reg [31:0] PRDATA_O,
	output wire PSLVERR_O,
	input wire BP_MODE_I,
	output reg MSG_REQ_O,
	output reg [1:0] MSG_KIND_O,
	output reg MSG_MULTI_O,
	output reg [7:0] MSG_DROP_O,
	output reg [7:0] MSG_UNIT_O,
	output reg [15:0] MSG_ADDR_O,
	output reg [15:0] MSG_DATA_O,
	input wire MSG_ACK_I,
	input wire [15:0] MSG_DATA_I,
	input wire RX_VALID_I,
	input wire [15:0] RX_ADDR_I,
	input wire [15:0] RX_DATA_I,
	output wire RX_READY_O,
	output reg REPLY_ERR_O,
	input wire PROG_OPEN_I,
	input wire PROG_ACT_I,
	output reg PROG_CLOSE_O,
	output wire SCAN_RUN_O,
	output wire [5:0] SCAN_SPAN_O,
	output wire IO_ONLY_O
);
	localparam S_IDLE = 2'h0;
	localparam S_RD = 2'h1;
	localparam S_WR = 2'h2;
	localparam S_BC = 2'h3;
	localparam DEPTH = 1 << IDX_W;

	reg [15:0] mbox [0:DEPTH-1];
	reg [15:0] ctrl_q, xfer_iv_q, route_q, rd_cnt_q, rd_from_q, rd_to_q;
	reg [15:0] wr_cnt_q, wr_to_q, wr_from_q, p_total_q, p_node_q, p_start_q;
	reg [15:0] p_cnt_q, p_dest_q, p_iv_q, reply_to_q, idle_to_q, span_q;
	reg [15:0] io_base_q, io_len_q;
	reg reply_err_q, overrun_q;
	reg mode_m_q, mode_s_q, mode_q;
	reg [1:0] mode_cnt_q;
	reg [1:0] st_q;
	reg [15:0] k_q, wait_q, xf_cnt_q, acc_q, min_sub_q, idle_min_q;
	reg [6:0] slot_q;
	reg [31:0] cent_q, ms_q;
	reg cent_tick, ms_tick;
	reg [31:0] rd_val;
	reg mapped;

	// Decoded APB access and mailbox window check.
	wire setup = PSEL_I & ~PENABLE_I;
	wire access = PSEL_I & PENABLE_I;
	wire is_mb = PADDR_I[`MBOX_BASE_BIT];
	wire [IDX_W-1:0] mb_idx = PADDR_I[IDX_W+1:2];
	wire [15:0] mb_idx16 = {{(16-IDX_W){1'b0}}, mb_idx};
	wire in_win = (mb_idx16 >= io_base_q) &&
		({1'b0, mb_idx16} < ({1'b0, io_base_q} + {1'b0, io_len_q}));
	wire mb_ok = is_mb & (~mode_q | in_win);
	wire bad = is_mb ? ~mb_ok : ~mapped;
	wire eng_store = (st_q == S_RD) & MSG_REQ_O & MSG_ACK_I;
	wire rx_take = RX_VALID_I & ~eng_store;
	wire mb_busy = is_mb & PWRITE_I & (eng_store | RX_VALID_I);
	wire wr_en = CE_I & access & PWRITE_I & ~mb_busy & ~bad;

	assign PREADY_O = ~mb_busy;
	assign PSLVERR_O = access & bad;
	assign RX_READY_O = ~eng_store;
	assign SCAN_RUN_O = ctrl_q[`CTRL_SCAN_EN];
	// Out-of-range span falls back to the reset span.
	wire [15:0] span_def = `RST_SCAN_SPAN;
	assign SCAN_SPAN_O = (span_q == 16'h0000 || span_q > `SCAN_SPAN_MAX) ?
		span_def[5:0] : span_q[5:0];
	assign IO_ONLY_O = mode_q;

	// Peer and periodic mode selection.
	wire peer_on = ctrl_q[`CTRL_PEER_EN];
	wire peer_ok = (p_total_q >= `PEER_TOTAL_MIN) &&
		(p_total_q <= `PEER_TOTAL_MAX) && (p_iv_q != 16'h0000);
	wire [15:0] acc_sum = acc_q + p_total_q;
	wire slot_wrap = ({9'h000, slot_q} + 16'h0001) >= p_total_q;
	wire [6:0] slot_next = slot_wrap ? 7'h00 : slot_q + 7'h01;
	wire slot_step = ms_tick & peer_on & peer_ok & (acc_sum >= p_iv_q);
	// Node zero and nodes above the total never send.
	wire bc_hit = slot_step & (p_node_q != 16'h0000) &&
		(p_node_q <= p_total_q) && (p_cnt_q != 16'h0000) &&
		({9'h000, slot_next} == p_node_q - 16'h0001);
	wire xf_hit = cent_tick & ~peer_on & (xfer_iv_q != 16'h0000) &&
		(xf_cnt_q + 16'h0001 >= xfer_iv_q);
	wire xf_go = xf_hit & ((rd_cnt_q != 16'h0000) | (wr_cnt_q != 16'h0000));
	// An ack in the expiry cycle still counts as a reply.
	wire timeout = MSG_REQ_O & ~MSG_ACK_I & cent_tick &&
		(wait_q + 16'h0001 >= reply_to_q);
	wire [15:0] cur_cnt = (st_q == S_RD) ? rd_cnt_q :
		(st_q == S_WR) ? wr_cnt_q : p_cnt_q;
	wire last = (k_q + 16'h0001) >= cur_cnt;

	// Address decode and read data mux for the register file.
	always @* begin
		mapped = 1'b1;
		rd_val = 32'h00000000;
		case (PADDR_I)
		`OFS_CTRL: rd_val[15:0] = ctrl_q;
		`OFS_XFER_INTERVAL: rd_val[15:0] = xfer_iv_q;
		`OFS_ROUTE: rd_val[15:0] = route_q;
		`OFS_READ_COUNT: rd_val[15:0] = rd_cnt_q;
		`OFS_READ_FROM: rd_val[15:0] = rd_from_q;
		`OFS_READ_TO: rd_val[15:0] = rd_to_q;
		`OFS_WRITE_COUNT: rd_val[15:0] = wr_cnt_q;
		`OFS_WRITE_TO: rd_val[15:0] = wr_to_q;
		`OFS_WRITE_FROM: rd_val[15:0] = wr_from_q;
		`OFS_PEER_TOTAL: rd_val[15:0] = p_total_q;
		`OFS_PEER_NODE: rd_val[15:0] = p_node_q;
		`OFS_PEER_START: rd_val[15:0] = p_start_q;
		`OFS_PEER_COUNT: rd_val[15:0] = p_cnt_q;
		`OFS_PEER_DEST: rd_val[15:0] = p_dest_q;
		`OFS_PEER_INTERVAL: rd_val[15:0] = p_iv_q;
		`OFS_REPLY_TIMEOUT: rd_val[15:0] = reply_to_q;
		`OFS_IDLE_TIMEOUT: rd_val[15:0] = idle_to_q;
		`OFS_SCAN_SPAN: rd_val[15:0] = span_q;
		`OFS_IO_BASE: rd_val[15:0] = io_base_q;
		`OFS_IO_LEN: rd_val[15:0] = io_len_q;
		`OFS_STATUS: rd_val[4:0] = {~peer_ok, mode_q, st_q != S_IDLE,
			overrun_q, reply_err_q};
		default: begin
			mapped = 1'b0;
			rd_val = is_mb ? {16'h0000, mbox[mb_idx]} : 32'h00000000;
		end
		endcase
	end

	// Read data is captured in the setup cycle and held through access.
	always @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			PRDATA_O <= 32'h00000000;
		end else if (CE_I && setup && !PWRITE_I) begin
			PRDATA_O <= bad ? 32'h00000000 : rd_val;
		end
	end

	// Mode strap is synchronised and caught once, at the third enabled edge
	// after reset release, when the second flip-flop holds the pin level.
	always @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			mode_m_q <= 1'b0;
			mode_s_q <= 1'b0;
			mode_q <= 1'b0;
			mode_cnt_q <= 2'h0;
		end else if (CE_I) begin
			mode_m_q <= BP_MODE_I;
			mode_s_q <= mode_m_q;
			if (mode_cnt_q != 2'h3) begin
				mode_cnt_q <= mode_cnt_q + 2'h1;
			end
			if (mode_cnt_q == 2'h2) begin
				mode_q <= mode_s_q;
			end
		end
	end

	// Configuration registers written by software.
	always @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			ctrl_q <= `RST_CTRL;
			xfer_iv_q <= `RST_XFER_INTERVAL;
			route_q <= 16'h0000;
			rd_cnt_q <= 16'h0000;
			rd_from_q <= 16'h0000;
			rd_to_q <= 16'h0000;
			wr_cnt_q <= 16'h0000;
			wr_to_q <= 16'h0000;
			wr_from_q <= 16'h0000;
			p_total_q <= `RST_PEER_TOTAL;
			p_node_q <= 16'h0000;
			p_start_q <= 16'h0000;
			p_cnt_q <= 16'h0000;
			p_dest_q <= 16'h0000;
			p_iv_q <= 16'h0000;
			reply_to_q <= `RST_REPLY_TIMEOUT;
			idle_to_q <= `RST_IDLE_TIMEOUT;
			span_q <= `RST_SCAN_SPAN;
			io_base_q <= 16'h0000;
			io_len_q <= 16'h0000;
		end else if (wr_en) begin
			case (PADDR_I)
			`OFS_CTRL: ctrl_q <= PWDATA_I[15:0];
			`OFS_XFER_INTERVAL: xfer_iv_q <= PWDATA_I[15:0];
			`OFS_ROUTE: route_q <= PWDATA_I[15:0];
			`OFS_READ_COUNT: rd_cnt_q <= PWDATA_I[15:0];
			`OFS_READ_FROM: rd_from_q <= PWDATA_I[15:0];
			`OFS_READ_TO: rd_to_q <= PWDATA_I[15:0];
			`OFS_WRITE_COUNT: wr_cnt_q <= PWDATA_I[15:0];
			`OFS_WRITE_TO: wr_to_q <= PWDATA_I[15:0];
			`OFS_WRITE_FROM: wr_from_q <= PWDATA_I[15:0];
			`OFS_PEER_TOTAL: p_total_q <= PWDATA_I[15:0];
			`OFS_PEER_NODE: p_node_q <= PWDATA_I[15:0];
			`OFS_PEER_START: p_start_q <= PWDATA_I[15:0];
			`OFS_PEER_COUNT: p_cnt_q <= PWDATA_I[15:0];
			`OFS_PEER_DEST: p_dest_q <= PWDATA_I[15:0];
			`OFS_PEER_INTERVAL: p_iv_q <= PWDATA_I[15:0];
			`OFS_REPLY_TIMEOUT: reply_to_q <= PWDATA_I[15:0];
			`OFS_IDLE_TIMEOUT: idle_to_q <= PWDATA_I[15:0];
			`OFS_SCAN_SPAN: span_q <= PWDATA_I[15:0];
			`OFS_IO_BASE: io_base_q <= PWDATA_I[15:0];
			`OFS_IO_LEN: io_len_q <= PWDATA_I[15:0];
			default: ;
			endcase
		end
	end

	// Mailbox writes: engine reply first, then peer receive, then software.
	always @(posedge SYS_CLK_I) begin
		if (CE_I) begin
			if (eng_store) begin
				mbox[rd_to_q[IDX_W-1:0] + k_q[IDX_W-1:0]] <= MSG_DATA_I;
			end else if (rx_take) begin
				mbox[RX_ADDR_I[IDX_W-1:0]] <= RX_DATA_I;
			end else if (wr_en && is_mb) begin
				mbox[mb_idx] <= PWDATA_I[15:0];
			end
		end
	end

	// Hundredth-second and millisecond tick prescalers.
	always @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			cent_q <= 32'h00000000;
			ms_q <= 32'h00000000;
			cent_tick <= 1'b0;
			ms_tick <= 1'b0;
		end else if (CE_I) begin
			cent_tick <= (cent_q == CENT_CYC - 1);
			ms_tick <= (ms_q == MS_CYC - 1);
			cent_q <= (cent_q == CENT_CYC - 1) ? 32'h00000000 : cent_q + 32'h1;
			ms_q <= (ms_q == MS_CYC - 1) ? 32'h00000000 : ms_q + 32'h1;
		end
	end

	// Interval timers, peer slot sequencer and status flags; set wins.
	always @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			xf_cnt_q <= 16'h0000;
			acc_q <= 16'h0000;
			slot_q <= 7'h00;
			reply_err_q <= 1'b0;
			overrun_q <= 1'b0;
		end else if (CE_I) begin
			if (cent_tick) begin
				xf_cnt_q <= xf_hit ? 16'h0000 : xf_cnt_q + 16'h0001;
			end
			if (!peer_on || !peer_ok) begin
				acc_q <= 16'h0000;
				slot_q <= 7'h00;
			end else if (ms_tick) begin
				acc_q <= slot_step ? acc_sum - p_iv_q : acc_sum;
				slot_q <= slot_step ? slot_next : slot_q;
			end
			if (wr_en && PADDR_I == `OFS_STATUS) begin
				reply_err_q <= reply_err_q & ~PWDATA_I[`ST_REPLY_ERR];
				overrun_q <= overrun_q & ~PWDATA_I[`ST_OVERRUN];
			end
			if (timeout) begin
				reply_err_q <= 1'b1;
			end
			if ((xf_go | bc_hit) && st_q != S_IDLE) begin
				overrun_q <= 1'b1;
			end
		end
	end

	// Transfer sequencer: one word message per handshake.
	always @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			st_q <= S_IDLE;
			k_q <= 16'h0000;
			wait_q <= 16'h0000;
			MSG_REQ_O <= 1'b0;
			MSG_KIND_O <= S_IDLE;
			MSG_MULTI_O <= 1'b0;
			MSG_DROP_O <= 8'h00;
			MSG_UNIT_O <= 8'h00;
			MSG_ADDR_O <= 16'h0000;
			MSG_DATA_O <= 16'h0000;
			REPLY_ERR_O <= 1'b0;
		end else if (CE_I) begin
			REPLY_ERR_O <= timeout;
			case (st_q)
			S_IDLE: begin
				k_q <= 16'h0000;
				if (bc_hit) begin
					st_q <= S_BC;
				end else if (xf_go) begin
					st_q <= (rd_cnt_q != 16'h0000) ? S_RD : S_WR;
				end
			end
			default: begin
				if (!MSG_REQ_O) begin
					MSG_REQ_O <= 1'b1;
					wait_q <= 16'h0000;
					MSG_KIND_O <= st_q;
					MSG_MULTI_O <= cur_cnt > 16'h0001;
					MSG_DROP_O <= route_q[7:0];
					MSG_UNIT_O <= route_q[15:8];
					case (st_q)
					S_RD: MSG_ADDR_O <= rd_from_q + k_q;
					S_WR: MSG_ADDR_O <= wr_to_q + k_q;
					default: MSG_ADDR_O <= p_dest_q + k_q;
					endcase
					MSG_DATA_O <= (st_q == S_RD) ? 16'h0000 :
						(st_q == S_WR) ?
						mbox[wr_from_q[IDX_W-1:0] + k_q[IDX_W-1:0]] :
						mbox[p_start_q[IDX_W-1:0] + k_q[IDX_W-1:0]];
				end else if (MSG_ACK_I) begin
					MSG_REQ_O <= 1'b0;
					k_q <= last ? 16'h0000 : k_q + 16'h0001;
					if (last) begin
						st_q <= (st_q == S_RD && wr_cnt_q != 16'h0000) ?
							S_WR : S_IDLE;
					end
				end else if (timeout) begin
					MSG_REQ_O <= 1'b0;
					st_q <= S_IDLE;
				end else if (cent_tick) begin
					wait_q <= wait_q + 16'h0001;
				end
			end
			endcase
		end
	end

	// Programming channel idle timer in minutes.
	always @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			min_sub_q <= 16'h0000;
			idle_min_q <= 16'h0000;
			PROG_CLOSE_O <= 1'b0;
		end else if (CE_I) begin
			PROG_CLOSE_O <= 1'b0;
			if (!PROG_OPEN_I || PROG_ACT_I) begin
				min_sub_q <= 16'h0000;
				idle_min_q <= 16'h0000;
			end else if (cent_tick) begin
				if (min_sub_q == `CENTS_PER_MINUTE - 1) begin
					min_sub_q <= 16'h0000;
					if (idle_min_q + 16'h0001 >= idle_to_q) begin
						idle_min_q <= 16'h0000;
						PROG_CLOSE_O <= 1'b1;
					end else begin
						idle_min_q <= idle_min_q + 16'h0001;
					end
				end else begin
					min_sub_q <= min_sub_q + 16'h0001;
				end
			end
		end
	end
endmodule // periodic_register_transfer_peer
`default_nettype wire

// *** src/xfer_peer_defs.vh ***
/*
 * Constants of the periodic register transfer and peer broadcast engine:
 * register byte offsets, field positions, reset values and timing figures.
 * Assumes a 100 MHz module clock and 32-bit APB with word registers.
 */
// Functional notes
// - Read count zero skips reads, one reads one word, more reads many.
// - Read words go from source register into consecutive mailbox words.
// - Write count zero skips writes, one writes one word, more writes many.
// - Write words come from consecutive mailbox words to target registers.
// - Peer total lies in 2..100 and matches on every member.
// - Node zero with peer on only listens and is not counted.
// - Broadcast sends a configured count of mailbox words from start index.
// - Broadcast names destination index; received words are stored there on.
// - Peer cycle ends within the millisecond interval, ideally total times two+.
// - Option mode gives full access; I/O-only mode only the assigned words.
// - Missing reply within timeout, in hundredths of seconds, returns an error.
// - Idle programming connection closes after the set minutes, default 16.
// - Enabled scanner issues table messages on the network; off by default.
// - Entries per socket span is 1 to 32, default 4.
// - Periodic transfers repeat once per interval in hundredths of seconds.
// - Peer off uses periodic settings; peer on uses peer settings.
`ifndef XFER_PEER_DEFS_VH
`define XFER_PEER_DEFS_VH
`define CLK_PERIOD_NS 10
`define CENT_NS 10000000
`define MILLI_NS 1000000
`define CENTS_PER_MINUTE 6000
`define OFS_CTRL 12'h000
`define OFS_XFER_INTERVAL 12'h004
`define OFS_ROUTE 12'h008
`define OFS_READ_COUNT 12'h00C
`define OFS_READ_FROM 12'h010
`define OFS_READ_TO 12'h014
`define OFS_WRITE_COUNT 12'h018
`define OFS_WRITE_TO 12'h01C
`define OFS_WRITE_FROM 12'h020
`define OFS_PEER_TOTAL 12'h024
`define OFS_PEER_NODE 12'h028
`define OFS_PEER_START 12'h02C
`define OFS_PEER_COUNT 12'h030
`define OFS_PEER_DEST 12'h034
`define OFS_PEER_INTERVAL 12'h038
`define OFS_REPLY_TIMEOUT 12'h03C
`define OFS_IDLE_TIMEOUT 12'h040
`define OFS_SCAN_SPAN 12'h044
`define OFS_IO_BASE 12'h048
`define OFS_IO_LEN 12'h04C
`define OFS_STATUS 12'h050
`define MBOX_BASE_BIT 11
`define CTRL_PEER_EN 0
`define CTRL_SCAN_EN 1
`define ST_REPLY_ERR 0
`define ST_OVERRUN 1
`define ST_BUSY 2
`define ST_IO_ONLY 3
`define ST_PEER_BAD 4
`define RST_CTRL 16'h0000
`define RST_XFER_INTERVAL 16'h0064
`define RST_REPLY_TIMEOUT 16'h03E8
`define RST_IDLE_TIMEOUT 16'h0010
`define RST_SCAN_SPAN 16'h0004
`define RST_PEER_TOTAL 16'h0002
`define PEER_TOTAL_MIN 16'h0002
`define PEER_TOTAL_MAX 16'h0064
`define SCAN_SPAN_MAX 16'h0020
`endif

// *** tb/net_peer_model.sv ***
/* Peripheral device and peer network on the engine's message link.
   Assumes the link contract: request held until a one-cycle ack. */
`timescale 1ns/1ps
`default_nettype none
module net_peer_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic [1:0] kind_i,
	input wire logic [7:0] drop_i,
	input wire logic [7:0] unit_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] data_i,
	input wire logic mute_i,
	input wire logic [3:0] lag_i,
	output logic ack_o,
	output logic [15:0] rdata_o
);
logic [15:0] regs [0:255];
logic [15:0] bc [0:255];
logic [3:0] wait_q;
logic [7:0] drop_q, unit_q;
int n_rd = 0, n_wr = 0, n_bc = 0;
// Peripheral registers hold a known pattern from the start.
initial begin
	for (int i = 0; i < 256; i++)
		regs[i] = 16'hA000 + 16'(i);
end
// Answers after lag cycles; read data is garbage outside the ack cycle.
always @(posedge clk_i) begin
	if (rst_i) begin
		ack_o <= 1'b0;
		wait_q <= 4'h0;
		rdata_o <= 16'h5A5A;
	end else if (req_i && !ack_o && !mute_i && wait_q == lag_i) begin
		ack_o <= 1'b1;
		wait_q <= 4'h0;
		drop_q <= drop_i;
		unit_q <= unit_i;
		rdata_o <= regs[addr_i[7:0]];
		if (kind_i == 2'h1)
			n_rd <= n_rd + 1;
		if (kind_i == 2'h2)
			regs[addr_i[7:0]] <= data_i;
		if (kind_i == 2'h2)
			n_wr <= n_wr + 1;
		if (kind_i == 2'h3)
			bc[addr_i[7:0]] <= data_i;
		if (kind_i == 2'h3)
			n_bc <= n_bc + 1;
	end else begin
		ack_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (req_i && !ack_o && !mute_i)
			wait_q <= wait_q + 4'h1;
	end
end
endmodule // net_peer_model
`default_nettype wire

// *** tb/periodic_register_transfer_peer_tb.sv ***
/* Self-checking bench of the periodic transfer and peer engine.
   Drives APB and the side pins; the network is a partner model. */
`timescale 1ns/1ps
`default_nettype none
`include "xfer_peer_defs.vh"
module periodic_register_transfer_peer_tb;
logic clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, pen = 1'b0;
logic pwr = 1'b0, bp = 1'b0, rxv = 1'b0, popen = 1'b0, pact = 1'b0;
logic mute = 1'b0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwd = 32'h0, q;
logic [15:0] rxa = 16'h0, rxd = 16'h0;
logic [3:0] lag = 4'h2;
logic e;
wire pready, pslverr, req, ack, rxr, rerr, pclose, srun, ioo, multi;
wire [31:0] prd;
wire [1:0] kind;
wire [7:0] drop, unit;
wire [15:0] maddr, mdata, rdat;
wire [5:0] span;
int error_cnt = 0, checks = 0, n, b0;
// One hundredth is four cycles and one millisecond ten.
periodic_register_transfer_peer #(.CENT_CYC(4), .MS_CYC(10)) uut (
	.SYS_CLK_I(clk), .RST_I(rst), .CE_I(ce), .PSEL_I(psel),
	.PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd),
	.PREADY_O(pready), .PRDATA_O(prd), .PSLVERR_O(pslverr), .BP_MODE_I(bp),
	.MSG_REQ_O(req), .MSG_KIND_O(kind), .MSG_MULTI_O(multi), .MSG_DROP_O(drop),
	.MSG_UNIT_O(unit), .MSG_ADDR_O(maddr), .MSG_DATA_O(mdata),
	.MSG_ACK_I(ack), .MSG_DATA_I(rdat), .RX_VALID_I(rxv), .RX_ADDR_I(rxa),
	.RX_DATA_I(rxd), .RX_READY_O(rxr), .REPLY_ERR_O(rerr),
	.PROG_OPEN_I(popen), .PROG_ACT_I(pact), .PROG_CLOSE_O(pclose),
	.SCAN_RUN_O(srun), .SCAN_SPAN_O(span), .IO_ONLY_O(ioo));
// The network side of the message link.
net_peer_model net (.clk_i(clk), .rst_i(rst), .req_i(req), .kind_i(kind),
	.drop_i(drop), .unit_i(unit), .addr_i(maddr), .data_i(mdata),
	.mute_i(mute), .lag_i(lag), .ack_o(ack), .rdata_o(rdat));
// Clock and a watchdog that ends a hung run.
initial forever #5 clk = ~clk;
initial begin
	#900000;
	error_cnt++;
	report_and_stop();
end
task automatic report_and_stop();
	if (error_cnt == 0 && checks > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
	checks++;
	if (g !== x) begin
		error_cnt++;
		$display("mismatch %s expected %h seen %h", s, x, g);
	end
endtask
// One APB transfer; ready, data and error are taken at the sampling edge.
task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
	@(posedge clk);
	psel <= 1'b1;
	pwr <= w;
	paddr <= a;
	pwd <= {16'h0000, d};
	@(posedge clk);
	pen <= 1'b1;
	@(posedge clk);
	while (pready !== 1'b1)
		@(posedge clk);
	q = prd;
	e = pslverr;
	psel <= 1'b0;
	pen <= 1'b0;
endtask
task automatic wr(input logic [11:0] a, input logic [15:0] d);
	apb(1'b1, a, d);
endtask
task automatic rc(input string s, input logic [11:0] a, input logic [31:0] x);
	apb(1'b0, a, 16'h0000);
	chk(s, x, q);
endtask
function automatic logic [11:0] mb(input logic [7:0] i);
	return 12'h800 + {2'b00, i, 2'b00};
endfunction
task automatic t_defaults();
	rc("interval", `OFS_XFER_INTERVAL, 32'h64);
	rc("reply timeout", `OFS_REPLY_TIMEOUT, 32'h3E8);
	rc("idle time", `OFS_IDLE_TIMEOUT, 32'h10);
	rc("span", `OFS_SCAN_SPAN, 32'h4);
	rc("ctrl", `OFS_CTRL, 32'h0);
	chk("scan run", 32'h0, {31'h0, srun});
endtask
task automatic t_periodic();
	for (int i = 0; i < 3; i++)
		wr(mb(8'h0A + 8'(i)), 16'hC000 + 16'(i));
	wr(`OFS_ROUTE, 16'h0703);
	wr(`OFS_READ_FROM, 16'h0020);
	wr(`OFS_READ_TO, 16'h0028);
	wr(`OFS_WRITE_FROM, 16'h000A);
	wr(`OFS_WRITE_TO, 16'h0050);
	wr(`OFS_WRITE_COUNT, 16'h0003);
	wr(`OFS_READ_COUNT, 16'h0002);
	wr(`OFS_XFER_INTERVAL, 16'h0019);
	while (req !== 1'b1)
		@(posedge clk);
	chk("multi flag", 32'h1, {31'h0, multi});
	while (net.n_wr < 3)
		@(posedge clk);
	rc("read word 0", mb(8'h28), 32'hA020);
	rc("read word 1", mb(8'h29), 32'hA021);
	for (int i = 0; i < 3; i++)
		chk("written word", 16'hC000 + i, net.regs[8'h50 + i]);
	chk("drop", 32'h3, {24'h0, net.drop_q});
	chk("unit", 32'h7, {24'h0, net.unit_q});
	// Single reads only, one per 40-cycle interval.
	wr(`OFS_WRITE_COUNT, 16'h0000);
	wr(`OFS_READ_COUNT, 16'h0001);
	wr(`OFS_XFER_INTERVAL, 16'h000A);
	n = net.n_rd;
	b0 = net.n_wr;
	repeat (400) @(posedge clk);
	n = net.n_rd - n;
	chk("reads per window", 32'h1, {31'h0, n >= 9 && n <= 11});
	chk("write count zero", b0, net.n_wr);
	while (req !== 1'b1)
		@(posedge clk);
	chk("single flag", 32'h0, {31'h0, multi});
endtask
task automatic t_timeout();
	mute <= 1'b1;
	wr(`OFS_REPLY_TIMEOUT, 16'h0005);
	n = 0;
	// Let a request already in flight end, so counting starts at a rise.
	@(negedge clk);
	while ((req !== 1'b0 || rerr !== 1'b0) && n < 200) begin
		n++;
		@(negedge clk);
	end
	n = 0;
	while (rerr !== 1'b1 && n < 200) begin
		n = n + {31'h0, req};
		@(negedge clk);
	end
	// Five hundredths of four cycles each, seen on a hundredth tick.
	chk("wait before error", 32'h1, {31'h0, n >= 17 && n <= 20});
	wr(`OFS_XFER_INTERVAL, 16'h0000);
	mute <= 1'b0;
	apb(1'b0, `OFS_STATUS, 16'h0000);
	chk("error flag", 32'h1, {31'h0, q[`ST_REPLY_ERR]});
	wr(`OFS_STATUS, 16'h0003);
	apb(1'b0, `OFS_STATUS, 16'h0000);
	chk("error flag cleared", 32'h0, {31'h0, q[`ST_REPLY_ERR]});
endtask
task automatic t_peer();
	wr(mb(8'h05), 16'hB005);
	wr(mb(8'h06), 16'hB006);
	wr(`OFS_PEER_INTERVAL, 16'h0004);
	wr(`OFS_PEER_TOTAL, 16'h0065);
	apb(1'b0, `OFS_STATUS, 16'h0000);
	chk("total 101 flagged", 32'h1, {31'h0, q[`ST_PEER_BAD]});
	wr(`OFS_PEER_TOTAL, 16'h0002);
	wr(`OFS_PEER_NODE, 16'h0002);
	wr(`OFS_PEER_START, 16'h0005);
	wr(`OFS_PEER_COUNT, 16'h0002);
	wr(`OFS_PEER_DEST, 16'h0030);
	apb(1'b0, `OFS_STATUS, 16'h0000);
	chk("total 2 accepted", 32'h0, {31'h0, q[`ST_PEER_BAD]});
	wr(`OFS_CTRL, 16'h0001);
	wr(`OFS_XFER_INTERVAL, 16'h000A);
	n = net.n_rd;
	while (net.n_bc < 2)
		@(posedge clk);
	b0 = net.n_bc;
	repeat (200) @(posedge clk);
	b0 = net.n_bc - b0;
	chk("words per 20 ms", 32'h1, {31'h0, b0 >= 8 && b0 <= 12});
	chk("sent word 0", 32'hB005, {16'h0, net.bc[8'h30]});
	chk("sent word 1", 32'hB006, {16'h0, net.bc[8'h31]});
	chk("no periodic reads", n, net.n_rd);
	@(posedge clk);
	rxv <= 1'b1;
	rxa <= 16'h0060;
	rxd <= 16'h1234;
	@(posedge clk);
	while (rxr !== 1'b1)
		@(posedge clk);
	rxv <= 1'b0;
	rc("received word", mb(8'h60), 32'h1234);
	wr(`OFS_PEER_NODE, 16'h0000);
	repeat (20) @(posedge clk);
	b0 = net.n_bc;
	repeat (200) @(posedge clk);
	chk("node zero silent", b0, net.n_bc);
	wr(`OFS_CTRL, 16'h0000);
	wr(`OFS_READ_COUNT, 16'h0000);
endtask
task automatic t_idle_scan();
	wr(`OFS_IDLE_TIMEOUT, 16'h0001);
	popen <= 1'b1;
	@(posedge clk);
	pact <= 1'b1;
	@(posedge clk);
	pact <= 1'b0;
	n = 0;
	@(negedge clk);
	while (pclose !== 1'b1 && n < 30000) begin
		n++;
		@(negedge clk);
	end
	chk("idle close", 32'h1, {31'h0, n >= 23990 && n <= 24010});
	@(posedge clk);
	popen <= 1'b0;
	wr(`OFS_CTRL, 16'h0002);
	wr(`OFS_SCAN_SPAN, 16'h0020);
	@(negedge clk);
	chk("scanner on", 32'h1, {31'h0, srun});
	chk("span 32", 32'h20, {26'h0, span});
	wr(`OFS_SCAN_SPAN, 16'h0021);
	@(negedge clk);
	chk("span 33 refused", 32'h4, {26'h0, span});
endtask
task automatic t_mode();
	bp <= 1'b1;
	repeat (5) @(posedge clk);
	chk("mode kept", 32'h0, {31'h0, ioo});
	rst <= 1'b1;
	repeat (4) @(posedge clk);
	rst <= 1'b0;
	repeat (5) @(posedge clk);
	chk("io only", 32'h1, {31'h0, ioo});
	wr(`OFS_IO_BASE, 16'h0000);
	wr(`OFS_IO_LEN, 16'h0004);
	apb(1'b1, mb(8'h02), 16'h0BEE);
	chk("inside window", 32'h0, {31'h0, e});
	apb(1'b1, mb(8'h08), 16'h0BEE);
	chk("outside window", 32'h1, {31'h0, e});
endtask
// Reset for four cycles, then every scenario in turn.
initial begin
	repeat (4) @(posedge clk);
	rst <= 1'b0;
	t_defaults();
	t_periodic();
	wr(`OFS_READ_COUNT, 16'h0001);
	t_timeout();
	t_peer();
	t_idle_scan();
	t_mode();
	report_and_stop();
end
endmodule // periodic_register_transfer_peer_tb
`default_nettype wire

// *** tb/xfer_peer_checker.sv ***
/* Concurrent checks on the transfer engine's message and status ports.
   Bound to the engine top; it sees that module's ports and nothing else. */
`timescale 1ns/1ps
`default_nettype none
module xfer_peer_checker (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic CE_I,
	input wire logic MSG_REQ_O,
	input wire logic [1:0] MSG_KIND_O,
	input wire logic [15:0] MSG_ADDR_O,
	input wire logic [15:0] MSG_DATA_O,
	input wire logic MSG_ACK_I,
	input wire logic REPLY_ERR_O,
	input wire logic PROG_CLOSE_O,
	input wire logic [5:0] SCAN_SPAN_O,
	input wire logic IO_ONLY_O
);
default clocking @(posedge SYS_CLK_I); endclocking
default disable iff (RST_I);
logic [2:0] run_q;
// Counts enabled edges since reset, saturating at seven.
always @(posedge SYS_CLK_I) begin
	if (RST_I)
		run_q <= 3'h0;
	else if (CE_I && run_q != 3'h7)
		run_q <= run_q + 3'h1;
end
// A word taken by the far side, and a word still waiting for it.
sequence s_acked; MSG_REQ_O && MSG_ACK_I && CE_I; endsequence
sequence s_waiting; MSG_REQ_O && !MSG_ACK_I ##1 MSG_REQ_O; endsequence
AST_ACK_DROP: assert property (s_acked |=> !MSG_REQ_O)
	else $error("request still up after ack");
AST_REQ_STABLE: assert property (s_waiting |-> $stable(MSG_ADDR_O) &&
	$stable(MSG_DATA_O) && $stable(MSG_KIND_O))
	else $error("message changed while waiting");
AST_KIND_SET: assert property (MSG_REQ_O |-> MSG_KIND_O != 2'h0)
	else $error("request without a kind");
AST_READ_NODATA: assert property (MSG_REQ_O && MSG_KIND_O == 2'h1 |->
	MSG_DATA_O == 16'h0000)
	else $error("read request carries data");
AST_ERR_PULSE: assert property (REPLY_ERR_O && CE_I |=> !REPLY_ERR_O)
	else $error("reply error longer than one cycle");
AST_ERR_CAUSE: assert property (REPLY_ERR_O |-> $past(MSG_REQ_O))
	else $error("reply error without a pending request");
AST_CLOSE_PULSE: assert property (PROG_CLOSE_O && CE_I |=> !PROG_CLOSE_O)
	else $error("close pulse longer than one cycle");
AST_SPAN_RANGE: assert property (SCAN_SPAN_O >= 6'h01 &&
	SCAN_SPAN_O <= 6'h20)
	else $error("socket span out of range");
AST_MODE_HELD: assert property (run_q >= 3'h5 |-> $stable(IO_ONLY_O))
	else $error("mode changed after it was latched");
endmodule // xfer_peer_checker
bind periodic_register_transfer_peer xfer_peer_checker chk (
	.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .CE_I(CE_I), .MSG_REQ_O(MSG_REQ_O),
	.MSG_KIND_O(MSG_KIND_O), .MSG_ADDR_O(MSG_ADDR_O), .MSG_DATA_O(MSG_DATA_O),
	.MSG_ACK_I(MSG_ACK_I), .REPLY_ERR_O(REPLY_ERR_O),
	.PROG_CLOSE_O(PROG_CLOSE_O), .SCAN_SPAN_O(SCAN_SPAN_O),
	.IO_ONLY_O(IO_ONLY_O));
`default_nettype wire
